// >>> rtl/pat_params.svh
// Purpose: Constants of the pulse accumulator timer port: offsets, bit positions, reset values, counts.
// Assumes: 8-bit register addresses, 16-bit data path on the register port.
// Notes: Included by the package, the synchronizer, the top module and the bench; definitions only.
`ifndef PAT_PARAMS_SVH
`define PAT_PARAMS_SVH

// Register offsets on the register port.
`define PAT_OFS_TIMER_COUNT   8'h84
`define PAT_OFS_SYS_CTRL      8'h86
`define PAT_OFS_PRESCALE      8'h8d
`define PAT_OFS_ACCUM_CTRL    8'ha0
`define PAT_OFS_ACCUM_FLAGS   8'ha1
`define PAT_OFS_ACCUM_COUNT   8'ha2
`define PAT_OFS_TEST_CTRL     8'had
`define PAT_OFS_PIN_DATA      8'hae
`define PAT_OFS_PIN_DIR       8'haf

// Timer system control bit positions.
`define PAT_BIT_TIMER_EN      7
`define PAT_BIT_DEBUG_FRZ     5
`define PAT_BIT_WAIT_FRZ      6
`define PAT_BIT_FAST_CLR      4

// Accumulator control bit positions.
`define PAT_BIT_ACC_EN        6
`define PAT_BIT_ACC_MODE      5
`define PAT_BIT_ACC_EDGE      4
`define PAT_BIT_CLK_SEL_HI    3
`define PAT_BIT_CLK_SEL_LO    2
`define PAT_BIT_OVF_IE        1
`define PAT_BIT_EDGE_IE       0

// Accumulator flag and test bit positions.
`define PAT_BIT_OVF_FLAG      1
`define PAT_BIT_EDGE_FLAG     0
`define PAT_BIT_CNT_BYP       1
`define PAT_BIT_ACC_BYP       0

// Pin carrying the accumulator input.
`define PAT_ACC_PIN           7

// Widths, reset values and counting constants.
`define PAT_ZERO8             8'h00
`define PAT_ZERO16            16'h0000
`define PAT_ONE8              8'h01
`define PAT_ONE16             16'h0001
`define PAT_ONES8             8'hff
`define PAT_ONES16            16'hffff
`define PAT_DIV64_LAST        6'h3f
`define PAT_PRE_ONE           6'h01
`define PAT_PRE_MAX_SEL       3'h5

`endif

// >>> rtl/pat_pkg.sv
// Purpose: Types of the pulse accumulator timer port.
// Assumes: Constants come from pat_params.svh.
// Notes: Holds the clock select encoding and the state record of each module.
`include "pat_params.svh"

package pat_pkg;

	// Counter clock source encoding of the two-bit select field.
	typedef enum logic [1:0]
	{
		PAT_CLK_PRESCALER = 2'h0,
		PAT_CLK_ACCUM     = 2'h1,
		PAT_CLK_ACCUM_256 = 2'h2,
		PAT_CLK_ACCUM_64K = 2'h3
	} pat_clk_sel_t;

	// Whole state of the top module.
	typedef struct packed
	{
		logic         timer_enable;
		logic         debug_freeze;
		logic         wait_freeze;
		logic         fast_flag_clear;
		logic [2:0]   prescale_sel;
		logic         accum_enable;
		logic         accum_mode_select;
		logic         accum_edge_select;
		pat_clk_sel_t clk_sel;
		logic         accum_overflow_irq_en;
		logic         accum_edge_irq_en;
		logic         accum_overflow_flag;
		logic         accum_edge_flag;
		logic [15:0]  accum_count;
		logic         counter_chain_bypass;
		logic         accum_chain_bypass;
		logic [7:0]   pin_latch;
		logic [7:0]   pin_dir;
		logic [15:0]  timer_count;
		logic [5:0]   prescale_count;
		logic         accum_in_prev;
		logic [15:0]  rdata;
	} pat_state_t;

	// Whole state of the input synchronizer.
	typedef struct packed
	{
		logic [7:0] stage1;
		logic [7:0] stage2;
	} pat_sync_state_t;

endpackage : pat_pkg

// >>> rtl/pat_sync.sv
// Purpose: Two-stage synchronizer for the eight timer port pins.
// Assumes: One clock, synchronous active-low reset.
// Notes: Only the second stage leaves this module.
`timescale 1ns/1ps
`default_nettype none
`include "pat_params.svh"

module pat_sync
(
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [7:0] pin_in,
	output logic      [7:0] pin_sync
);

	// Registered state and its next value.
	pat_pkg::pat_sync_state_t sync_reg;
	pat_pkg::pat_sync_state_t sync_next;

	////////////////////////////////////////////////////////////////////////////////
	// The first stage feeds only the second stage, so no logic sees a metastable level.
	always_comb
	begin
		sync_next        = sync_reg;
		sync_next.stage1 = pin_in;
		sync_next.stage2 = sync_reg.stage1;
	end

	// State register with synchronous reset.
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			sync_reg <= '0;
		end
		else
		begin
			sync_reg <= sync_next;
		end
	end

	// Settled pin levels.
	assign pin_sync = sync_reg.stage2;

endmodule : pat_sync
`default_nettype wire

// >>> rtl/pat_top.sv
// Purpose: Pulse accumulator, timer counter clock choice, flags and timer port pins.
// Assumes: All inputs but pin_in synchronous to mclk; register reads answer one cycle after the strobe.
// Notes: Input capture and output compare channels live outside; the compare channels hand in their enables and levels.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "pat_params.svh"

module pat_top
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr_strobe,
	input  wire logic        rd_strobe,
	output logic      [15:0] rdata,
	input  wire logic        special_mode_n,
	input  wire logic        stop_mode,
	input  wire logic        debug_mode,
	input  wire logic        wait_mode,
	input  wire logic [7:0]  compare_enable,
	input  wire logic [7:0]  compare_level,
	input  wire logic [7:0]  pin_in,
	output logic      [7:0]  pin_out,
	output logic      [7:0]  pin_oe,
	output logic             accum_overflow_irq,
	output logic             accum_edge_irq,
	output logic      [15:0] timer_count
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	pat_pkg::pat_state_t st_reg;          // Registered state.
	pat_pkg::pat_state_t st_next;         // Next state.
	logic [7:0]          pin_sync;        // Synchronized pin levels.
	logic [7:0]          pin_read;        // Level seen by a data register read.
	logic                frozen;          // Freeze by stop, debug or wait.
	logic                timer_run;       // Timer section allowed to count.
	logic                accum_run;       // Accumulator section allowed to count.
	logic [5:0]          prescale_mask;   // Low prescaler bits that must be ones.
	logic                prescale_tick;   // Prescaler output pulse.
	logic                div64_tick;      // Module clock divided by 64.
	logic                accum_in;        // Synchronized accumulator input.
	logic                rise;            // Rising edge of the input.
	logic                fall;            // Falling edge of the input.
	logic                counted_edge;    // Edge counted in event mode.
	logic                trailing_edge;   // End of the gate in gated mode.
	logic                gate_open;       // Gate at its active level.
	logic                accum_clock;     // One accumulator count pulse.
	logic                accum_lo_wrap;   // Low byte rolls over.
	logic                accum_wrap;      // Whole accumulator rolls over.
	logic                counter_tick;    // Timer counter increment pulse.
	logic                count_access;    // Any access of the count register.
	logic                wr_hit_flags;    // Write to the flag register.

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronizer.

	pat_sync u_sync
	(
		.mclk     (mclk),
		.rstn     (rstn),
		.pin_in   (pin_in),
		.pin_sync (pin_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Pin drive: one slice per pin.

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_pin
			assign pin_oe[gi]   = st_reg.pin_dir[gi] | compare_enable[gi];
			assign pin_out[gi]  = compare_enable[gi] ? compare_level[gi] : st_reg.pin_latch[gi];
			assign pin_read[gi] = pin_oe[gi] ? pin_out[gi] : pin_sync[gi];
		end
	endgenerate
	// is carried by pin_dir above: a one drives the pin, a zero leaves it an input unless its compare_enable bit is set.

	////////////////////////////////////////////////////////////////////////////////
	// Clock sources and events, all as one-cycle enables on mclk.
	always_comb
	begin
		frozen        = stop_mode | (debug_mode & st_reg.debug_freeze) | (wait_mode & st_reg.wait_freeze);
		timer_run     = st_reg.timer_enable & ~frozen;
		accum_run     = st_reg.accum_enable & ~frozen;
		// Reserved prescaler codes fall back to the largest factor.
		if (st_reg.prescale_sel > `PAT_PRE_MAX_SEL)
		begin
			prescale_mask = 6'((`PAT_PRE_ONE << `PAT_PRE_MAX_SEL) - `PAT_PRE_ONE);
		end
		else
		begin
			prescale_mask = 6'((`PAT_PRE_ONE << st_reg.prescale_sel) - `PAT_PRE_ONE);
		end
		prescale_tick = timer_run & ((st_reg.prescale_count & prescale_mask) == prescale_mask);
		div64_tick    = timer_run & (st_reg.prescale_count == `PAT_DIV64_LAST);
		accum_in      = pin_sync[`PAT_ACC_PIN];
		rise          = accum_in & ~st_reg.accum_in_prev;
		fall          = ~accum_in & st_reg.accum_in_prev;
		counted_edge  = st_reg.accum_edge_select ? rise : fall;
		// A low-active gate ends on the rising edge, a high-active one on the falling edge.
		gate_open     = st_reg.accum_edge_select ? ~accum_in : accum_in;
		trailing_edge = st_reg.accum_edge_select ? rise : fall;
		if (st_reg.accum_mode_select)
		begin
			accum_clock = accum_run & gate_open & (st_reg.accum_chain_bypass | div64_tick);
		end
		else
		begin
			accum_clock = accum_run & counted_edge;
		end
		accum_lo_wrap = accum_clock & (st_reg.accum_count[7:0] == `PAT_ONES8);
		accum_wrap    = accum_clock & (st_reg.accum_count == `PAT_ONES16);
		if (!st_reg.accum_enable)
		begin
			counter_tick = prescale_tick;
		end
		else
		begin
			case (st_reg.clk_sel)
				pat_pkg::PAT_CLK_PRESCALER : counter_tick = prescale_tick;
				pat_pkg::PAT_CLK_ACCUM     : counter_tick = accum_clock;
				pat_pkg::PAT_CLK_ACCUM_256 : counter_tick = accum_lo_wrap;
				pat_pkg::PAT_CLK_ACCUM_64K : counter_tick = accum_wrap;
				default                    : counter_tick = prescale_tick;
			endcase
		end
		if (st_reg.counter_chain_bypass)
		begin
			counter_tick = timer_run;
		end
		// The counter never moves while the timer section is stopped.
		counter_tick  = counter_tick & timer_run;
		count_access  = (wr_strobe | rd_strobe) & (addr == `PAT_OFS_ACCUM_COUNT);
		wr_hit_flags  = wr_strobe & (addr == `PAT_OFS_ACCUM_FLAGS);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state: counters, flags, register writes and read data.
	always_comb
	begin
		st_next               = st_reg;
		st_next.accum_in_prev = accum_in;
		// The prescaler only advances while the timer section runs.
		if (timer_run)
		begin
			st_next.prescale_count = st_reg.prescale_count + `PAT_PRE_ONE;
		end
		// Timer counter, whole or as two free halves.
		if (counter_tick)
		begin
			if (st_reg.counter_chain_bypass)
			begin
				st_next.timer_count[15:8] = st_reg.timer_count[15:8] + `PAT_ONE8;
				st_next.timer_count[7:0]  = st_reg.timer_count[7:0] + `PAT_ONE8;
			end
			else
			begin
				st_next.timer_count = st_reg.timer_count + `PAT_ONE16;
			end
		end
		// Accumulator counter, whole or as two free halves.
		if (accum_clock)
		begin
			if (st_reg.accum_chain_bypass)
			begin
				st_next.accum_count[15:8] = st_reg.accum_count[15:8] + `PAT_ONE8;
				st_next.accum_count[7:0]  = st_reg.accum_count[7:0] + `PAT_ONE8;
			end
			else
			begin
				st_next.accum_count = st_reg.accum_count + `PAT_ONE16;
			end
		end

		// Register writes; a software load of the count beats a same-cycle increment.
		if (wr_strobe)
		begin
			case (addr)
				`PAT_OFS_SYS_CTRL :
				begin
					st_next.timer_enable    = wdata[`PAT_BIT_TIMER_EN];
					st_next.debug_freeze    = wdata[`PAT_BIT_DEBUG_FRZ];
					st_next.wait_freeze     = wdata[`PAT_BIT_WAIT_FRZ];
					st_next.fast_flag_clear = wdata[`PAT_BIT_FAST_CLR];
				end
				`PAT_OFS_PRESCALE :
				begin
					st_next.prescale_sel = wdata[2:0];
				end
				`PAT_OFS_ACCUM_CTRL :
				begin
					st_next.accum_enable          = wdata[`PAT_BIT_ACC_EN];
					st_next.accum_mode_select     = wdata[`PAT_BIT_ACC_MODE];
					st_next.accum_edge_select     = wdata[`PAT_BIT_ACC_EDGE];
					st_next.clk_sel               = pat_pkg::pat_clk_sel_t'(
						{wdata[`PAT_BIT_CLK_SEL_HI], wdata[`PAT_BIT_CLK_SEL_LO]});
					st_next.accum_overflow_irq_en = wdata[`PAT_BIT_OVF_IE];
					st_next.accum_edge_irq_en     = wdata[`PAT_BIT_EDGE_IE];
				end
				`PAT_OFS_ACCUM_COUNT :
				begin
					st_next.accum_count = wdata;
				end
				`PAT_OFS_TEST_CTRL :
				begin
					if (!special_mode_n)
					begin
						st_next.counter_chain_bypass = wdata[`PAT_BIT_CNT_BYP];
						st_next.accum_chain_bypass   = wdata[`PAT_BIT_ACC_BYP];
					end
				end
				`PAT_OFS_PIN_DATA :
				begin
					st_next.pin_latch = wdata[7:0];
				end
				`PAT_OFS_PIN_DIR :
				begin
					st_next.pin_dir = wdata[7:0];
				end
				default :
				begin
					// Other addresses, read-only ones included, take no write here; flag register writes clear flags below.
					st_next.pin_dir = st_reg.pin_dir;
				end
			endcase
		end

		// Flag clearing first, so that a same-cycle event below wins.
		if (wr_hit_flags)
		begin
			if (wdata[`PAT_BIT_OVF_FLAG])
			begin
				st_next.accum_overflow_flag = 1'b0;
			end
			if (wdata[`PAT_BIT_EDGE_FLAG])
			begin
				st_next.accum_edge_flag = 1'b0;
			end
		end
		if (count_access && st_reg.fast_flag_clear)
		begin
			st_next.accum_overflow_flag = 1'b0;
			st_next.accum_edge_flag     = 1'b0;
		end
		if (accum_wrap)
		begin
			st_next.accum_overflow_flag = 1'b1;
		end
		if (accum_run && (st_reg.accum_mode_select ? trailing_edge : counted_edge))
		begin
			st_next.accum_edge_flag = 1'b1;
		end

		// Read data, valid in the cycle after the strobe; unmapped addresses read zero.
		st_next.rdata = `PAT_ZERO16;
		if (rd_strobe)
		begin
			case (addr)
				`PAT_OFS_TIMER_COUNT :
				begin
					st_next.rdata = st_reg.timer_count;
				end
				`PAT_OFS_SYS_CTRL :
				begin
					st_next.rdata[`PAT_BIT_TIMER_EN]  = st_reg.timer_enable;
					st_next.rdata[`PAT_BIT_DEBUG_FRZ] = st_reg.debug_freeze;
					st_next.rdata[`PAT_BIT_WAIT_FRZ]  = st_reg.wait_freeze;
					st_next.rdata[`PAT_BIT_FAST_CLR]  = st_reg.fast_flag_clear;
				end
				`PAT_OFS_PRESCALE :
				begin
					st_next.rdata[2:0] = st_reg.prescale_sel;
				end
				`PAT_OFS_ACCUM_CTRL :
				begin
					st_next.rdata[`PAT_BIT_ACC_EN]     = st_reg.accum_enable;
					st_next.rdata[`PAT_BIT_ACC_MODE]   = st_reg.accum_mode_select;
					st_next.rdata[`PAT_BIT_ACC_EDGE]   = st_reg.accum_edge_select;
					st_next.rdata[`PAT_BIT_CLK_SEL_HI] = st_reg.clk_sel[1];
					st_next.rdata[`PAT_BIT_CLK_SEL_LO] = st_reg.clk_sel[0];
					st_next.rdata[`PAT_BIT_OVF_IE]     = st_reg.accum_overflow_irq_en;
					st_next.rdata[`PAT_BIT_EDGE_IE]    = st_reg.accum_edge_irq_en;
				end
				`PAT_OFS_ACCUM_FLAGS :
				begin
					st_next.rdata[`PAT_BIT_OVF_FLAG]  = st_reg.accum_overflow_flag;
					st_next.rdata[`PAT_BIT_EDGE_FLAG] = st_reg.accum_edge_flag;
				end
				`PAT_OFS_ACCUM_COUNT :
				begin
					st_next.rdata = st_reg.accum_count;
				end
				`PAT_OFS_TEST_CTRL :
				begin
					st_next.rdata[`PAT_BIT_CNT_BYP] = st_reg.counter_chain_bypass;
					st_next.rdata[`PAT_BIT_ACC_BYP] = st_reg.accum_chain_bypass;
				end
				`PAT_OFS_PIN_DATA :
				begin
					st_next.rdata[7:0] = pin_read;
				end
				`PAT_OFS_PIN_DIR :
				begin
					st_next.rdata[7:0] = st_reg.pin_dir;
				end
				default :
				begin
					st_next.rdata = `PAT_ZERO16;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; synchronous reset clears everything.
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign rdata              = st_reg.rdata;
	assign timer_count        = st_reg.timer_count;
	assign accum_overflow_irq = st_reg.accum_overflow_flag & st_reg.accum_overflow_irq_en;
	assign accum_edge_irq     = st_reg.accum_edge_flag & st_reg.accum_edge_irq_en;

endmodule : pat_top
`default_nettype wire

// >>> test/pat_monitor.sv
// Purpose: Port-level checker for pat_top.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Attached by the bind statement at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module pat_monitor
(
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic [7:0]  addr,
	input wire logic        wr_strobe,
	input wire logic        rd_strobe,
	input wire logic [15:0] rdata,
	input wire logic        stop_mode,
	input wire logic [7:0]  compare_enable,
	input wire logic [7:0]  compare_level,
	input wire logic [7:0]  pin_in,
	input wire logic [7:0]  pin_out,
	input wire logic [7:0]  pin_oe,
	input wire logic        accum_overflow_irq,
	input wire logic        accum_edge_irq,
	input wire logic [15:0] timer_count
);
	// Every check shares the one clock; reset masks them all.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////
	// read answer, counter, flag request and pin checks
	rdata_idle_a: assert property (!$past(rd_strobe) |-> rdata == 16'h0000)
		else $error("read data seen outside an answer cycle");
	count_word_a: assert property (rd_strobe && addr == 8'h84 |=> rdata == $past(timer_count))
		else $error("timer count read is not the counter word");
	stop_hold_a: assert property (stop_mode |=> $stable(timer_count))
		else $error("timer counter moved in stop mode");
	edge_fall_a: assert property ($fell(accum_edge_irq) |-> $past(wr_strobe) || $past(rd_strobe))
		else $error("edge request dropped without an access");
	ovf_fall_a: assert property ($fell(accum_overflow_irq) |-> $past(wr_strobe) || $past(rd_strobe))
		else $error("overflow request dropped without an access");
	edge_rise_a: assert property ($rose(accum_edge_irq) |-> $past(wr_strobe)
		|| $past(pin_in[7], 2) != $past(pin_in[7], 3) || $past(pin_in[7], 3) != $past(pin_in[7], 4))
		else $error("edge request rose with no pin edge");
	oe_cause_a: assert property ($changed(pin_oe) |-> $changed(compare_enable) || $past(wr_strobe))
		else $error("pin enables changed with no cause");
	cmp_force_a: assert property ((compare_enable & ~pin_oe) == 8'h00)
		else $error("enabled compare pin not driven");
	cmp_level_a: assert property ((pin_out & compare_enable) == (compare_level & compare_enable))
		else $error("compare pin not at compare level");

	// Main scenarios seen.
	cover property ($rose(accum_edge_irq));
	cover property ($rose(accum_overflow_irq));
	cover property (rd_strobe && addr == 8'ha2);
endmodule : pat_monitor

bind pat_top pat_monitor u_mon
(
	.mclk(mclk), .rstn(rstn), .addr(addr), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
	.rdata(rdata), .stop_mode(stop_mode), .compare_enable(compare_enable),
	.compare_level(compare_level), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
	.accum_overflow_irq(accum_overflow_irq), .accum_edge_irq(accum_edge_irq), .timer_count(timer_count)
);
`default_nettype wire

// >>> test/pat_pin_model.sv
// Purpose: Far side of the timer pins: pulse sources and loads.
// Assumes: A driven pin reads back the level the block drives.
// Notes: Undriven pins follow the source levels the bench sets.
`timescale 1ns/1ps
`default_nettype none

module pat_pin_model
(
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_level,
	output logic      [7:0] pin_in
);
	// source width
	// Driven pins show the driver; inputs show the source, held wide by the bench.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pat_pin_model
`default_nettype wire

// >>> test/pat_top_bench.sv
// Purpose: Self-checking bench for pat_top.
// Assumes: 20 MHz clock, register reads answer one cycle later.
// Notes: Pin 7 carries the accumulator source; pin 7 idles high.
`timescale 1ns/1ps
`default_nettype none
`include "pat_params.svh"

module pat_top_bench;
	logic        mclk;
	logic        rstn;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic        wr_strobe;
	logic        rd_strobe;
	logic [15:0] rdata;
	logic        special_mode_n;
	logic        stop_mode;
	logic        debug_mode;
	logic        wait_mode;
	logic [7:0]  compare_enable;
	logic [7:0]  compare_level;
	logic [7:0]  pin_in;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe;
	logic        accum_overflow_irq;
	logic        accum_edge_irq;
	logic [15:0] timer_count;
	logic [7:0]  ext_level;
	int          n_errors;
	int          checks;
	logic [15:0] v;
	logic [15:0] t0;

	pat_top DUT (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
		.rd_strobe(rd_strobe), .rdata(rdata), .special_mode_n(special_mode_n), .stop_mode(stop_mode),
		.debug_mode(debug_mode), .wait_mode(wait_mode), .compare_enable(compare_enable),
		.compare_level(compare_level), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.accum_overflow_irq(accum_overflow_irq), .accum_edge_irq(accum_edge_irq), .timer_count(timer_count));
	pat_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

	////////////////////////////////////////////////////////////
	// Waits n edges, then steps past them so outputs are settled.
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : idle

	// One write cycle; strobe drops after the taking edge.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr      <= a;
		wdata     <= d;
		wr_strobe <= 1'b1;
		@(posedge mclk);
		wr_strobe <= 1'b0;
		#1;
	endtask : wr

	// One read cycle; the answer stands only in the next cycle.
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge mclk);
		addr      <= a;
		rd_strobe <= 1'b1;
		@(posedge mclk);
		rd_strobe <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// wide pulse
	// Low for five clocks: a shorter pulse could slip past the synchronizer.
	task automatic pulse();
		@(posedge mclk) ext_level[7] <= 1'b0;
		idle(4);
		@(posedge mclk) ext_level[7] <= 1'b1;
		idle(5);
	endtask : pulse

	////////////////////////////////////////////////////////////
	task automatic t_reset_pins();
		rd(`PAT_OFS_PIN_DATA, v);
		chk("pin data inputs", {8'h00, ext_level}, v);
		rd(8'hff, v);
		chk("unmapped read", 16'h0000, v);
		wr(`PAT_OFS_PIN_DIR, 16'h000f);
		wr(`PAT_OFS_PIN_DATA, 16'h00a5);
		chk("pin enables", 16'h000f, pin_oe);
		chk("pin drive", 16'h0005, pin_out & 8'h0f);
		idle(3);
		rd(`PAT_OFS_PIN_DATA, v);
		chk("pin data mixed", {8'h00, 8'h05 | (ext_level & 8'hf0)}, v);
		@(posedge mclk) compare_enable <= 8'h10;
		wr(`PAT_OFS_PIN_DATA, 16'h00ff);
		chk("compare forces", 16'h001f, pin_oe);
		chk("compare keeps level", 16'h0000, pin_out[4]);
		rd(`PAT_OFS_PIN_DIR, v);
		chk("direction kept", 16'h000f, v);
		@(posedge mclk) compare_enable <= 8'h00;
		wr(`PAT_OFS_PIN_DIR, 16'h001f);
		chk("latched level", 16'h0001, pin_out[4]);
		wr(`PAT_OFS_PIN_DIR, 16'h0000);
		$display("test pins done");
	endtask : t_reset_pins

	task automatic t_event_flags();
		wr(`PAT_OFS_ACCUM_CTRL, 16'h0043);
		pulse();
		rd(`PAT_OFS_ACCUM_COUNT, v);
		chk("event count", 16'h0001, v);
		chk("edge request", 16'h0001, accum_edge_irq);
		wr(`PAT_OFS_ACCUM_FLAGS, 16'h0002);
		chk("edge flag kept", 16'h0001, accum_edge_irq);
		wr(`PAT_OFS_ACCUM_FLAGS, 16'h0001);
		chk("edge flag cleared", 16'h0000, accum_edge_irq);
		wr(`PAT_OFS_ACCUM_COUNT, 16'hffff);
		pulse();
		chk("overflow request", 16'h0001, accum_overflow_irq);
		rd(`PAT_OFS_ACCUM_COUNT, v);
		chk("wrap to zero", 16'h0000, v);
		wr(`PAT_OFS_ACCUM_FLAGS, 16'h0002);
		chk("overflow cleared", 16'h0000, accum_overflow_irq);
		wr(`PAT_OFS_SYS_CTRL, 16'h0010);
		rd(`PAT_OFS_ACCUM_COUNT, v);
		chk("fast clear", 16'h0000, accum_edge_irq);
		wr(`PAT_OFS_SYS_CTRL, 16'h0000);
		wr(`PAT_OFS_ACCUM_CTRL, 16'h0001);
		pulse();
		rd(`PAT_OFS_ACCUM_COUNT, v);
		chk("disabled count", 16'h0000, v);
		chk("disabled flag", 16'h0000, accum_edge_irq);
		$display("test flags done");
	endtask : t_event_flags

	task automatic t_gated();
		wr(`PAT_OFS_ACCUM_CTRL, 16'h0061);
		idle(200);
		rd(`PAT_OFS_ACCUM_COUNT, v);
		chk("no tick timer off", 16'h0000, v);
		wr(`PAT_OFS_SYS_CTRL, 16'h0080);
		idle(256);
		rd(`PAT_OFS_ACCUM_COUNT, v);
		// One divide-64 tick every 64 clocks from a prescaler that starts at zero.
		chk("gated ticks", 16'h0004, v);
		@(posedge mclk) ext_level[7] <= 1'b0;
		idle(5);
		chk("trailing edge flag", 16'h0001, accum_edge_irq);
		@(posedge mclk) ext_level[7] <= 1'b1;
		wr(`PAT_OFS_ACCUM_FLAGS, 16'h0001);
		$display("test gated done");
	endtask : t_gated

	task automatic t_timer_clock();
		wr(`PAT_OFS_ACCUM_COUNT, 16'h0000);
		wr(`PAT_OFS_ACCUM_CTRL, 16'h0044);
		t0 = timer_count;
		idle(20);
		chk("accum clock idle", t0, timer_count);
		pulse();
		chk("accum clock step", t0 + 16'h0001, timer_count);
		// Two edges but only one low-byte wrap: a direct clock would step twice.
		wr(`PAT_OFS_ACCUM_COUNT, 16'h00fe);
		wr(`PAT_OFS_ACCUM_CTRL, 16'h0048);
		t0 = timer_count;
		pulse();
		pulse();
		chk("accum clock div256", t0 + 16'h0001, timer_count);
		wr(`PAT_OFS_ACCUM_CTRL, 16'h0004);
		t0 = timer_count;
		idle(5);
		chk("prescaler forced", t0 + 16'h0005, timer_count);
		@(posedge mclk) stop_mode <= 1'b1;
		idle(1);
		t0 = timer_count;
		idle(5);
		chk("stop holds", t0, timer_count);
		rd(`PAT_OFS_TIMER_COUNT, v);
		chk("count read", t0, v);
		@(posedge mclk) stop_mode <= 1'b0;
		wr(`PAT_OFS_SYS_CTRL, 16'h00e0);
		@(posedge mclk) debug_mode <= 1'b1;
		idle(1);
		t0 = timer_count;
		idle(5);
		chk("debug freeze", t0, timer_count);
		@(posedge mclk) debug_mode <= 1'b0;
		wait_mode <= 1'b1;
		idle(1);
		t0 = timer_count;
		idle(5);
		chk("wait freeze", t0, timer_count);
		@(posedge mclk) wait_mode <= 1'b0;
		$display("test timer clock done");
	endtask : t_timer_clock

	task automatic t_test_reg();
		wr(`PAT_OFS_SYS_CTRL, 16'h0000);
		wr(`PAT_OFS_TEST_CTRL, 16'h0003);
		rd(`PAT_OFS_TEST_CTRL, v);
		chk("test locked", 16'h0000, v);
		@(posedge mclk) special_mode_n <= 1'b0;
		wr(`PAT_OFS_TEST_CTRL, 16'h0002);
		rd(`PAT_OFS_TEST_CTRL, v);
		chk("test open", 16'h0002, v);
		wr(`PAT_OFS_PRESCALE, 16'h0003);
		wr(`PAT_OFS_SYS_CTRL, 16'h0080);
		t0 = timer_count;
		idle(3);
		chk("split halves", {t0[15:8] + 8'h03, t0[7:0] + 8'h03}, timer_count);
		// Rising-edge events with the accumulator split: both halves step once.
		wr(`PAT_OFS_ACCUM_COUNT, 16'h0000);
		wr(`PAT_OFS_ACCUM_CTRL, 16'h0050);
		wr(`PAT_OFS_TEST_CTRL, 16'h0001);
		pulse();
		rd(`PAT_OFS_ACCUM_COUNT, v);
		chk("split accumulator", 16'h0101, v);
		wr(`PAT_OFS_TEST_CTRL, 16'h0000);
		@(posedge mclk) special_mode_n <= 1'b1;
		$display("test bypass done");
	endtask : t_test_reg

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	////////////////////////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Whole run is about 700 clocks; this cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		give_verdict();
	end

	initial
	begin
		n_errors = 0;
		checks = 0;
		rstn = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		wr_strobe = 1'b0;
		rd_strobe = 1'b0;
		special_mode_n = 1'b1;
		stop_mode = 1'b0;
		debug_mode = 1'b0;
		wait_mode = 1'b0;
		compare_enable = 8'h00;
		compare_level = 8'h00;
		ext_level = 8'hc3;
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		idle(1);
		t_reset_pins();
		t_event_flags();
		t_gated();
		t_timer_clock();
		t_test_reg();
		give_verdict();
	end
endmodule : pat_top_bench
`default_nettype wire
